// ---- core/liucfg_top.sv ----
// Primary configuration bank of the eight-channel line interface: soft
// reset, monitor select, loopback, alarm criteria, auto all-ones, global
// overrides and indirect per-channel template selection.
// Assumes a plain register port with one-cycle strobes, and per-channel
// settings and loss status arriving from other banks on mclk.
`timescale 1ns/1ns
`default_nettype none
`include "liucfg_map.svh"
module liucfg_top #(
    parameter bit DEFAULT_120 = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Channel status and per-channel settings from other banks
    input wire liucfg_pkg::liucfg_chan_vec_t los_in,
    input wire liucfg_pkg::liucfg_chan_vec_t per_channel_alarm_on_loss,
    input wire liucfg_pkg::liucfg_chan_vec_t per_channel_short_protect_off,
    input wire liucfg_pkg::liucfg_chan_vec_t per_channel_line_code,
    input wire liucfg_pkg::liucfg_chan_vec_t per_channel_jitter_depth,
    input wire liucfg_pkg::liucfg_chan_vec_t per_channel_jitter_position,
    input wire liucfg_pkg::liucfg_chan_vec_t per_channel_jitter_enable,
    // Soft reset and monitoring
    output logic soft_reset_active,
    output logic monitor_enable,
    output logic monitor_tx,
    output liucfg_pkg::liucfg_chan_idx_t monitor_channel,
    // Per-channel datapath controls
    output liucfg_pkg::liucfg_chan_vec_t digital_loopback,
    output liucfg_pkg::liucfg_chan_vec_t criteria_etsi,
    output liucfg_pkg::liucfg_chan_vec_t criteria_t1,
    output liucfg_pkg::liucfg_chan_vec_t tx_all_ones,
    output liucfg_pkg::liucfg_chan_vec_t ais_to_system,
    output liucfg_pkg::liucfg_chan_vec_t short_protect_off,
    output liucfg_pkg::liucfg_chan_vec_t line_ami,
    output liucfg_pkg::liucfg_chan_vec_t jitter_depth_128,
    output liucfg_pkg::liucfg_chan_vec_t jitter_in_rx,
    output liucfg_pkg::liucfg_chan_vec_t jitter_enable,
    // Termination and template controls
    output logic rx_internal_term,
    output liucfg_pkg::liucfg_chan_vec_t rx_int_adjust,
    output liucfg_pkg::liucfg_chan_vec_t rx_match_off,
    output liucfg_pkg::liucfg_chan_vec_t tx_term_off,
    output liucfg_pkg::liucfg_chan_vec_t e1_imp_120,
    output liucfg_pkg::liucfg_chan_vec_t t1_imp_110,
    output liucfg_pkg::liucfg_chan_vec_t e1_mode,
    output liucfg_pkg::liucfg_chan_vec_t template_reserved
);
    import liucfg_pkg::*;

    // Software-visible registers
    liucfg_byte_t bank_ptr_r;
    liucfg_byte_t monitor_select_field_r;
    liucfg_chan_vec_t digital_loopback_bit_r;
    liucfg_chan_vec_t loss_alarm_criteria_bit_r;
    liucfg_chan_vec_t auto_ones_on_loss_bit_r;
    liucfg_byte_t global_override_config_r;
    liucfg_byte_t template_channel_pointer_r;
    liucfg_byte_t template_channel_pointer_nxt;

    // Decoded access strobes
    logic primary_sel;
    logic wr_any;
    logic wr_soft_reset;
    logic wr_monitor;
    logic wr_loopback;
    logic wr_criteria;
    logic wr_auto_ones;
    logic wr_global;
    logic wr_tmpl_ptr;
    logic wr_tmpl_sel;
    logic wr_bank_ptr;
    logic swr_active;
    liucfg_byte_t rdata_nxt;

    // Global override fields
    logic gc_alarm_on_loss;
    logic gc_short_off;
    logic gc_ami;
    logic gc_depth;
    logic gc_ja_pos;
    logic gc_ja_en;

    // Per-channel template decode
    liucfg_chan_vec_t tmpl_rx_match_off;
    liucfg_chan_vec_t tmpl_tx_term_off;
    liucfg_chan_vec_t tmpl_imp_choice;
    liucfg_chan_vec_t tmpl_e1;
    liucfg_chan_vec_t tmpl_reserved;

    liucfg_tmpl_if tmpl ();

    // Soft reset pulse
    liucfg_swrst u_swrst (
        .mclk(mclk),
        .reset_n(reset_n),
        .trigger(wr_soft_reset),
        .active_r(swr_active)
    );

    // Per-channel template bytes
    liucfg_tmpl_mem u_tmpl_mem (
        .mclk(mclk),
        .reset_n(reset_n),
        .port(tmpl.store)
    );

    // Address decode; the bank registers other than the bank pointer only answer in the primary bank
    assign primary_sel = (bank_ptr_r == `LIUCFG_BANK_PRIMARY);
    assign wr_any = reg_wr && !swr_active;
    assign wr_soft_reset = wr_any && primary_sel && reg_addr == `LIUCFG_OFS_SOFT_RESET;
    assign wr_monitor = wr_any && primary_sel && reg_addr == `LIUCFG_OFS_MONITOR;
    assign wr_loopback = wr_any && primary_sel && reg_addr == `LIUCFG_OFS_LOOPBACK;
    assign wr_criteria = wr_any && primary_sel && reg_addr == `LIUCFG_OFS_CRITERIA;
    assign wr_auto_ones = wr_any && primary_sel && reg_addr == `LIUCFG_OFS_AUTO_ONES;
    assign wr_global = wr_any && primary_sel && reg_addr == `LIUCFG_OFS_GLOBAL;
    assign wr_tmpl_ptr = wr_any && primary_sel && reg_addr == `LIUCFG_OFS_TMPL_PTR;
    assign wr_tmpl_sel = wr_any && primary_sel && reg_addr == `LIUCFG_OFS_TMPL_SEL;
    assign wr_bank_ptr = wr_any && reg_addr == `LIUCFG_OFS_BANK_PTR;

    // Global override fields
    assign gc_alarm_on_loss = global_override_config_r[`LIUCFG_GC_ALARM_ON_LOSS];
    assign gc_short_off = global_override_config_r[`LIUCFG_GC_SHORT_OFF];
    assign gc_ami = global_override_config_r[`LIUCFG_GC_AMI];
    assign gc_depth = global_override_config_r[`LIUCFG_GC_DEPTH];
    assign gc_ja_pos = global_override_config_r[`LIUCFG_GC_JA_POS];
    assign gc_ja_en = global_override_config_r[`LIUCFG_GC_JA_EN];

    // Template pointer next value, used to aim the store's read port early
    always_comb begin
        template_channel_pointer_nxt = template_channel_pointer_r;
        if (swr_active) begin
            template_channel_pointer_nxt = `LIUCFG_RESET_VALUE;
        end else if (wr_tmpl_ptr) begin
            template_channel_pointer_nxt = reg_wdata & `LIUCFG_TMPL_PTR_MASK;
        end
    end

    // Template store access through the channel pointer
    assign tmpl.clear = swr_active;
    assign tmpl.wr_en = wr_tmpl_sel;
    assign tmpl.wr_idx = template_channel_pointer_r[2:0];
    assign tmpl.wr_data = reg_wdata;
    assign tmpl.rd_idx = template_channel_pointer_nxt[2:0];

    // Template byte fields per channel
    for (genvar ch = 0; ch < 8; ch++) begin : g_tmpl
        logic [7:0] entry;
        liucfg_tmpl_code_t code;
        assign entry = tmpl.entries[ch*8 +: 8];
        assign code = liucfg_tmpl_code_t'(entry[`LIUCFG_TS_MODE_HI:`LIUCFG_TS_MODE_LO]);
        assign tmpl_rx_match_off[ch] = entry[`LIUCFG_TS_RX_MATCH_OFF];
        assign tmpl_tx_term_off[ch] = entry[`LIUCFG_TS_TX_TERM_OFF];
        assign tmpl_imp_choice[ch] = entry[`LIUCFG_TS_IMP_CHOICE];
        assign tmpl_e1[ch] = (code == LIUCFG_TMPL_E1);
        assign tmpl_reserved[ch] = (code == LIUCFG_TMPL_RSV1) || (code == LIUCFG_TMPL_RSV2);
    end

    // Bank pointer; reachable from every bank, cleared by soft reset too
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bank_ptr_r <= `LIUCFG_RESET_VALUE;
        end else if (swr_active) begin
            bank_ptr_r <= `LIUCFG_RESET_VALUE;
        end else if (wr_bank_ptr) begin
            bank_ptr_r <= reg_wdata;
        end
    end

    // Monitor select field, reserved upper nibble kept at zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            monitor_select_field_r <= `LIUCFG_RESET_VALUE;
        end else if (swr_active) begin
            monitor_select_field_r <= `LIUCFG_RESET_VALUE;
        end else if (wr_monitor) begin
            monitor_select_field_r <= reg_wdata & `LIUCFG_MONITOR_MASK;
        end
    end

    // Per-channel bit registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            digital_loopback_bit_r <= `LIUCFG_RESET_VALUE;
            loss_alarm_criteria_bit_r <= `LIUCFG_RESET_VALUE;
            auto_ones_on_loss_bit_r <= `LIUCFG_RESET_VALUE;
        end else if (swr_active) begin
            digital_loopback_bit_r <= `LIUCFG_RESET_VALUE;
            loss_alarm_criteria_bit_r <= `LIUCFG_RESET_VALUE;
            auto_ones_on_loss_bit_r <= `LIUCFG_RESET_VALUE;
        end else begin
            if (wr_loopback) begin
                digital_loopback_bit_r <= reg_wdata;
            end
            if (wr_criteria) begin
                loss_alarm_criteria_bit_r <= reg_wdata;
            end
            if (wr_auto_ones) begin
                auto_ones_on_loss_bit_r <= reg_wdata;
            end
        end
    end

    // Global overrides and template channel pointer
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            global_override_config_r <= `LIUCFG_RESET_VALUE;
            template_channel_pointer_r <= `LIUCFG_RESET_VALUE;
        end else begin
            template_channel_pointer_r <= template_channel_pointer_nxt;
            if (swr_active) begin
                global_override_config_r <= `LIUCFG_RESET_VALUE;
            end else if (wr_global) begin
                global_override_config_r <= reg_wdata & `LIUCFG_GLOBAL_MASK;
            end
        end
    end

    // Read mux; soft reset reads zero, unmapped and other banks read zero, except the bank pointer in every bank
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_addr == `LIUCFG_OFS_BANK_PTR) begin
            rdata_nxt = bank_ptr_r;
        end else if (primary_sel) begin
            case (reg_addr)
                `LIUCFG_OFS_SOFT_RESET: rdata_nxt = 8'h00;
                `LIUCFG_OFS_MONITOR: rdata_nxt = monitor_select_field_r;
                `LIUCFG_OFS_LOOPBACK: rdata_nxt = digital_loopback_bit_r;
                `LIUCFG_OFS_CRITERIA: rdata_nxt = loss_alarm_criteria_bit_r;
                `LIUCFG_OFS_AUTO_ONES: rdata_nxt = auto_ones_on_loss_bit_r;
                `LIUCFG_OFS_GLOBAL: rdata_nxt = global_override_config_r;
                `LIUCFG_OFS_TMPL_PTR: rdata_nxt = template_channel_pointer_r;
                `LIUCFG_OFS_TMPL_SEL: rdata_nxt = tmpl.rd_data;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Read data stand for the one cycle after the read strobe
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Soft reset indication follows the pulse generator by one cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            soft_reset_active <= 1'b0;
        end else begin
            soft_reset_active <= swr_active;
        end
    end

    // Monitor routing: low three bits name channel, top bit picks transmitter
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            monitor_enable <= 1'b0;
            monitor_tx <= 1'b0;
            monitor_channel <= 3'h0;
        end else begin
            monitor_enable <= (monitor_select_field_r[2:0] != 3'h0);
            monitor_tx <= monitor_select_field_r[`LIUCFG_MON_TX_BIT];
            monitor_channel <= monitor_select_field_r[2:0];
        end
    end

    // Loopback, alarm criteria and automatic all-ones
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            digital_loopback <= 8'h00;
            criteria_etsi <= 8'h00;
            criteria_t1 <= 8'h00;
            tx_all_ones <= 8'h00;
        end else begin
            digital_loopback <= digital_loopback_bit_r;
            criteria_etsi <= loss_alarm_criteria_bit_r & tmpl_e1;
            criteria_t1 <= ~tmpl_e1;
            tx_all_ones <= auto_ones_on_loss_bit_r & los_in;
        end
    end

    // Global overrides over the per-channel settings
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ais_to_system <= 8'h00;
            short_protect_off <= 8'h00;
            line_ami <= 8'h00;
            jitter_depth_128 <= 8'h00;
        end else begin
            ais_to_system <= los_in & (per_channel_alarm_on_loss | {8{gc_alarm_on_loss}});
            short_protect_off <= per_channel_short_protect_off | {8{gc_short_off}};
            line_ami <= per_channel_line_code | {8{gc_ami}};
            jitter_depth_128 <= per_channel_jitter_depth | {8{gc_depth}};
        end
    end

    // Jitter attenuator enable and position
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            jitter_enable <= 8'h00;
            jitter_in_rx <= 8'h00;
        end else begin
            jitter_enable <= per_channel_jitter_enable | {8{gc_ja_en}};
            if (gc_ja_en) begin
                jitter_in_rx <= {8{gc_ja_pos}};
            end else begin
                jitter_in_rx <= {8{gc_ja_pos}} ^ per_channel_jitter_position;
            end
        end
    end

    // Termination, impedance and template mode per channel
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_internal_term <= 1'b0;
            rx_int_adjust <= 8'h00;
            rx_match_off <= 8'h00;
            tx_term_off <= 8'h00;
            e1_imp_120 <= 8'h00;
            t1_imp_110 <= 8'h00;
            e1_mode <= 8'h00;
            template_reserved <= 8'h00;
        end else begin
            rx_internal_term <= global_override_config_r[`LIUCFG_GC_RX_INT_TERM];
            // External mode still trims internally except for E1 at 120 ohm
            rx_int_adjust <= ~(tmpl_e1 & e1_imp_nxt());
            rx_match_off <= tmpl_rx_match_off;
            tx_term_off <= tmpl_tx_term_off;
            e1_imp_120 <= e1_imp_nxt();
            t1_imp_110 <= tmpl_imp_choice;
            e1_mode <= tmpl_e1;
            template_reserved <= tmpl_reserved;
        end
    end

    // E1 impedance is 120 ohm when the choice bit differs from the variant
    function automatic liucfg_chan_vec_t e1_imp_nxt();
        if (DEFAULT_120) begin
            return ~tmpl_imp_choice;
        end
        return tmpl_imp_choice;
    endfunction : e1_imp_nxt
endmodule : liucfg_top
`default_nettype wire

// ---- common/liucfg_map.svh ----
// Register offsets, field positions, reset values and timing counts of the
// line interface primary configuration bank. Included by the design files.
`ifndef LIUCFG_MAP_SVH
`define LIUCFG_MAP_SVH

`define LIUCFG_OFS_SOFT_RESET 8'h0a
`define LIUCFG_OFS_MONITOR 8'h0b
`define LIUCFG_OFS_LOOPBACK 8'h0c
`define LIUCFG_OFS_CRITERIA 8'h0d
`define LIUCFG_OFS_AUTO_ONES 8'h0e
`define LIUCFG_OFS_GLOBAL 8'h0f
`define LIUCFG_OFS_TMPL_PTR 8'h10
`define LIUCFG_OFS_TMPL_SEL 8'h11
`define LIUCFG_OFS_BANK_PTR 8'h1f

`define LIUCFG_BANK_PRIMARY 8'h00
`define LIUCFG_RESET_VALUE 8'h00
`define LIUCFG_MONITOR_MASK 8'h0f
`define LIUCFG_GLOBAL_MASK 8'hfb
`define LIUCFG_TMPL_PTR_MASK 8'h07
`define LIUCFG_TMPL_SEL_MASK 8'hcf

`define LIUCFG_GC_RX_INT_TERM 7
`define LIUCFG_GC_ALARM_ON_LOSS 6
`define LIUCFG_GC_SHORT_OFF 5
`define LIUCFG_GC_AMI 4
`define LIUCFG_GC_DEPTH 3
`define LIUCFG_GC_JA_POS 1
`define LIUCFG_GC_JA_EN 0

`define LIUCFG_TS_RX_MATCH_OFF 7
`define LIUCFG_TS_TX_TERM_OFF 6
`define LIUCFG_TS_IMP_CHOICE 3
`define LIUCFG_TS_MODE_HI 2
`define LIUCFG_TS_MODE_LO 0
`define LIUCFG_MON_TX_BIT 3

`define LIUCFG_CLK_PERIOD_NS 8
`define LIUCFG_SWR_TIME_NS 1000
`define LIUCFG_SWR_CYCLES ((`LIUCFG_SWR_TIME_NS + `LIUCFG_CLK_PERIOD_NS - 1) / `LIUCFG_CLK_PERIOD_NS)

`endif

// ---- common/liucfg_pkg.sv ----
// Types shared by the primary configuration bank modules.
// Assumes an eight-channel line interface with byte-wide registers.
package liucfg_pkg;
    typedef logic [7:0] liucfg_byte_t;
    typedef logic [7:0] liucfg_chan_vec_t;
    typedef logic [2:0] liucfg_chan_idx_t;
    typedef logic [2:0] liucfg_template_t;

    // Line templates of the three-bit template field
    typedef enum logic [2:0] {
        LIUCFG_TMPL_E1 = 3'h0,
        LIUCFG_TMPL_RSV1 = 3'h1,
        LIUCFG_TMPL_RSV2 = 3'h2,
        LIUCFG_TMPL_T1_0 = 3'h3,
        LIUCFG_TMPL_T1_1 = 3'h4,
        LIUCFG_TMPL_T1_2 = 3'h5,
        LIUCFG_TMPL_T1_3 = 3'h6,
        LIUCFG_TMPL_T1_4 = 3'h7
    } liucfg_tmpl_code_t;
endpackage : liucfg_pkg

// ---- common/liucfg_tmpl_if.sv ----
// Bundle between the bank and the per-channel template store.
// Assumes one clock; the bank is the only writer.
`timescale 1ns/1ns
`default_nettype none
interface liucfg_tmpl_if;
    logic clear;
    logic wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [2:0] rd_idx;
    logic [7:0] rd_data;
    logic [63:0] entries;

    modport bank (output clear, output wr_en, output wr_idx, output wr_data,
        output rd_idx, input rd_data, input entries);
    modport store (input clear, input wr_en, input wr_idx, input wr_data,
        input rd_idx, output rd_data, output entries);
endinterface : liucfg_tmpl_if
`default_nettype wire

// ---- core/liucfg_swrst.sv ----
// Soft reset pulse generator: a trigger starts a pulse of fixed length.
// Assumes the trigger is a one-cycle strobe on mclk.
`timescale 1ns/1ns
`default_nettype none
`include "liucfg_map.svh"
module liucfg_swrst (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Control
    input wire logic trigger,
    output logic active_r
);
    localparam logic [7:0] PULSE_CYCLES = 8'(`LIUCFG_SWR_CYCLES);
    logic [7:0] count_r;

    // A new trigger restarts the pulse, so it never falls short
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= 8'h00;
            active_r <= 1'b0;
        end else if (trigger) begin
            count_r <= PULSE_CYCLES - 8'h01;
            active_r <= 1'b1;
        end else if (count_r != 8'h00) begin
            count_r <= count_r - 8'h01;
        end else begin
            active_r <= 1'b0;
        end
    end
endmodule : liucfg_swrst
`default_nettype wire

// ---- core/liucfg_tmpl_mem.sv ----
// Eight-entry template store, one byte per channel, registered read data.
// Assumes the reader sets rd_idx to the index it wants in the next cycle.
`timescale 1ns/1ns
`default_nettype none
`include "liucfg_map.svh"
module liucfg_tmpl_mem (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Access from the bank
    liucfg_tmpl_if.store port
);
    logic [7:0] mem_r [8];

    // One byte per channel, cleared by either reset
    for (genvar ch = 0; ch < 8; ch++) begin : g_entry
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                mem_r[ch] <= `LIUCFG_RESET_VALUE;
            end else if (port.clear) begin
                mem_r[ch] <= `LIUCFG_RESET_VALUE;
            end else if (port.wr_en && port.wr_idx == 3'(ch)) begin
                mem_r[ch] <= port.wr_data & `LIUCFG_TMPL_SEL_MASK;
            end
        end
        assign port.entries[ch*8 +: 8] = mem_r[ch];
    end

    // Read data with write-through so a fresh write reads back at once
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            port.rd_data <= 8'h00;
        end else if (port.clear) begin
            port.rd_data <= 8'h00;
        end else if (port.wr_en && port.wr_idx == port.rd_idx) begin
            port.rd_data <= port.wr_data & `LIUCFG_TMPL_SEL_MASK;
        end else begin
            port.rd_data <= mem_r[port.rd_idx];
        end
    end
endmodule : liucfg_tmpl_mem
`default_nettype wire

// ---- tb/liucfg_top_properties.sv ----
// Port-level checks on the primary configuration bank, bound into the top.
// Assumes registered outputs follow their causes by one mclk cycle.
`timescale 1ns/1ns
`default_nettype none
module liucfg_props #(parameter bit DEFAULT_120 = 1'b1) (
    // Clock, reset, single-bit status and monitor channel
    input wire logic mclk, reset_n, soft_reset_active, monitor_enable,
    input wire logic [2:0] monitor_channel,
    // Per-channel inputs and outputs
    input wire logic [7:0] los_in, per_channel_alarm_on_loss, per_channel_short_protect_off,
    input wire logic [7:0] per_channel_line_code, per_channel_jitter_depth, per_channel_jitter_enable,
    input wire logic [7:0] digital_loopback, tx_all_ones, ais_to_system, short_protect_off, line_ami,
    input wire logic [7:0] jitter_depth_128, jitter_enable, criteria_etsi, criteria_t1, e1_mode,
    input wire logic [7:0] e1_imp_120, t1_imp_110
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic [7:0] on_cnt_r;
    // Length of the current soft reset indication
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) on_cnt_r <= 8'h00;
        else on_cnt_r <= soft_reset_active ? on_cnt_r + 8'h01 : 8'h00;
    end
    chk_swr_pulse_len: assert property ($fell(soft_reset_active) |-> on_cnt_r == 8'h7d)
        else $error("soft reset pulse length wrong");
    chk_swr_holds_zero: assert property (soft_reset_active && $past(soft_reset_active) |->
        digital_loopback == 8'h00 && line_ami == $past(per_channel_line_code)) else $error("not held");
    chk_monitor_code: assert property (monitor_enable == (monitor_channel != 3'h0))
        else $error("monitor enable wrong");
    chk_ones_need_loss: assert property ((tx_all_ones & ~$past(los_in)) == 8'h00)
        else $error("all ones without loss");
    chk_ais_override: assert property ($past(reset_n) |-> ais_to_system == $past(los_in) ||
        ais_to_system == ($past(los_in) & $past(per_channel_alarm_on_loss))) else $error("ais wrong");
    chk_short_override: assert property ($past(reset_n) |-> short_protect_off == 8'hff ||
        short_protect_off == $past(per_channel_short_protect_off)) else $error("short wrong");
    chk_ami_override: assert property ($past(reset_n) |-> line_ami == 8'hff ||
        line_ami == $past(per_channel_line_code)) else $error("line code wrong");
    chk_depth_override: assert property ($past(reset_n) |-> jitter_depth_128 == 8'hff ||
        jitter_depth_128 == $past(per_channel_jitter_depth)) else $error("depth wrong");
    chk_ja_override: assert property ($past(reset_n) |-> jitter_enable == 8'hff ||
        jitter_enable == $past(per_channel_jitter_enable)) else $error("jitter enable wrong");
    chk_criteria_split: assert property ($past(reset_n) |-> criteria_t1 == ~e1_mode &&
        (criteria_etsi & criteria_t1) == 8'h00) else $error("criteria wrong");
    chk_imp_variant: assert property ($past(reset_n) |->
        e1_imp_120 == (DEFAULT_120 ? ~t1_imp_110 : t1_imp_110)) else $error("impedance wrong");
endmodule : liucfg_props
bind liucfg_top liucfg_props #(.DEFAULT_120(DEFAULT_120)) i_props (.*);
`default_nettype wire

// ---- tb/liucfg_top_tb.sv ----
// Self-checking bench for the primary configuration bank.
// Assumes the top module with its register port driven directly.
`timescale 1ns/1ns
`default_nettype none
module liucfg_top_tb;
    import liucfg_pkg::*;
    logic mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
    logic soft_reset_active, monitor_enable, monitor_tx, rx_internal_term;
    logic [2:0] monitor_channel;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, tp [8];
    logic [7:0] msk [6] = '{8'h0f, 8'hff, 8'hff, 8'hff, 8'hfb, 8'h07};
    logic [7:0] los_in, per_channel_alarm_on_loss, per_channel_short_protect_off;
    logic [7:0] per_channel_line_code, per_channel_jitter_depth, per_channel_jitter_position;
    logic [7:0] per_channel_jitter_enable, digital_loopback, criteria_etsi, criteria_t1;
    logic [7:0] tx_all_ones, ais_to_system, short_protect_off, line_ami, jitter_depth_128;
    logic [7:0] jitter_in_rx, jitter_enable, rx_int_adjust, rx_match_off, tx_term_off;
    logic [7:0] e1_imp_120, t1_imp_110, e1_mode, template_reserved, exp_q [$];
    logic [63:0] rnd = 64'h0;
    int failures = 0, checked = 0;
    liucfg_top i_dut (.*);
    // Channel status and per-channel settings wander randomly
    assign {los_in, per_channel_alarm_on_loss, per_channel_short_protect_off, per_channel_line_code,
        per_channel_jitter_depth, per_channel_jitter_position, per_channel_jitter_enable} = rnd[55:0];
    always #4 mclk = ~mclk;
    // New random inputs each cycle and a note of the read strobe
    always @(posedge mclk) begin
        rnd <= {$urandom, $urandom};
        rd_q <= reg_rd;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, r, a, d};
        @(posedge mclk);
    endtask : cyc
    task automatic idle;
        cyc(1'b0, 1'b0, 8'h00, 8'h00);
    endtask : idle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cyc(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    // Read data is compared in the cycle after its strobe
    always @(negedge mclk) if (rd_q) check(reg_rdata, exp_q.pop_front());
    task automatic print_verdict;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // Cuts a hang short
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
    // Main sequence
    initial begin
        int i;
        logic [7:0] d;
        void'($urandom(32'hed16f481));
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        for (i = 10; i <= 17; i++) rd(8'(i), 8'h00);
        for (i = 0; i < 6; i++) begin
            d = 8'($urandom);
            cyc(1'b1, 1'b0, 8'(11 + i), d);
            rd(8'(11 + i), d & msk[i]);
        end
        for (i = 0; i < 16; i++) begin
            if (i < 8) tp[i] = 8'($urandom);
            cyc(1'b1, 1'b0, (i < 8) ? 8'h10 : 8'h0b, 8'(i % 8));
            if (i < 8) cyc(1'b1, 1'b0, 8'h11, tp[i]);
        end
        for (i = 0; i < 8; i++) begin
            cyc(1'b1, 1'b0, 8'h10, 8'(i));
            rd(8'h11, tp[i] & 8'hcf);
        end
        // Per-channel template decode against the bytes written
        for (i = 0; i < 8; i++) begin
            check({6'h0, rx_match_off[i], tx_term_off[i]}, 8'(tp[i][7:6]));
            check({6'h0, e1_imp_120[i], t1_imp_110[i]}, {6'h0, ~tp[i][3], tp[i][3]});
            check({7'h0, rx_int_adjust[i]}, 8'(tp[i][2:0] != 3'h0 || tp[i][3]));
            check({7'h0, e1_mode[i]}, 8'(tp[i][2:0] == 3'h0));
            check({7'h0, template_reserved[i]},
                8'(tp[i][2:0] == 3'h1 || tp[i][2:0] == 3'h2));
        end
        for (i = 0; i < 16; i++) begin
            cyc(1'b1, 1'b0, 8'h0b, 8'(i));
            idle();
            idle();
            check({3'h0, monitor_enable, monitor_tx, monitor_channel}, {3'h0, i[2:0] != 3'h0, 4'(i)});
        end
        cyc(1'b1, 1'b0, 8'h0c, 8'h5a);
        cyc(1'b1, 1'b0, 8'h1f, 8'haa);
        cyc(1'b1, 1'b0, 8'h0c, 8'h3c);
        rd(8'h0c, 8'h00);
        cyc(1'b1, 1'b0, 8'h1f, 8'h00);
        cyc(1'b1, 1'b0, 8'h0f, 8'hff);
        rd(8'h0c, 8'h5a);
        idle();
        check(digital_loopback, 8'h5a);
        check(line_ami, 8'hff);
        check({7'h0, rx_internal_term}, 8'h01);
        check(jitter_in_rx, 8'hff);
        check(jitter_enable, 8'hff);
        cyc(1'b1, 1'b0, 8'h0a, 8'($urandom));
        repeat (3) idle();
        rd(8'h0f, 8'h00);
        for (i = 0; i < 200 && soft_reset_active === 1'b1; i++) idle();
        idle();
        rd(8'h0c, 8'h00);
        rd(8'h11, 8'h00);
        idle();
        idle();
        print_verdict();
    end
endmodule : liucfg_top_tb
`default_nettype wire
